// [sdcp_pkg.sv]
package sdcp_pkg;
  localparam int SDCP_ROW_W = 12;
  localparam int SDCP_COL_W = 9;
  localparam int SDCP_DATA_W = 16;
  localparam int SDCP_BANKS = 4;
  localparam int SDCP_AP_BIT = 10;
  localparam int SDCP_MODE_BL_LSB = 0;
  localparam int SDCP_MODE_BT_BIT = 3;
  localparam int SDCP_MODE_CL_LSB = 4;
  localparam logic [2:0] SDCP_BL_1 = 3'h0;
  localparam logic [2:0] SDCP_BL_2 = 3'h1;
  localparam logic [2:0] SDCP_BL_4 = 3'h2;
  localparam logic [2:0] SDCP_BL_8 = 3'h3;
  localparam logic [2:0] SDCP_BL_FULL = 3'h7;
  localparam logic [2:0] SDCP_CL_RESET = 3'h2;
  localparam logic [2:0] SDCP_BL_RESET = 3'h0;
  localparam int SDCP_TWR_CYC = 2;
  localparam int SDCP_TRP_NS = 20;
  localparam int SDCP_CLK_MHZ = 100;
  localparam int SDCP_TRP_CYC = (SDCP_TRP_NS * SDCP_CLK_MHZ + 999) / 1000;
  localparam int SDCP_TMRD_CYC = 2;
  // Command pins in order cs_n, ras_n, cas_n, we_n
  localparam logic [3:0] SDCP_CMD_ACT = 4'h3;
  localparam logic [3:0] SDCP_CMD_READ = 4'h5;
  localparam logic [3:0] SDCP_CMD_WRITE = 4'h4;
  localparam logic [3:0] SDCP_CMD_MRS = 4'h0;
  localparam logic [3:0] SDCP_CMD_REF = 4'h1;
  localparam logic [3:0] SDCP_CMD_STOP = 4'h6;
  localparam logic [3:0] SDCP_CMD_PRE = 4'h2;
  localparam logic [3:0] SDCP_CMD_NOP = 4'h7;
  localparam logic [3:0] SDCP_CMD_DESEL = 4'hf;
  typedef enum logic [2:0] {
    SDCP_OP_NOP, SDCP_OP_ACT, SDCP_OP_READ, SDCP_OP_WRITE, SDCP_OP_PRE,
    SDCP_OP_REF, SDCP_OP_SREF, SDCP_OP_MRS
  } sdcp_op_t;
endpackage

// [sdcp_if.sv]
`timescale 1ns/1ps
interface sdcp_if;
  import sdcp_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_low;
  logic bank_select_high;
  logic [SDCP_ROW_W-1:0] addr;
  logic dqm;
  logic [SDCP_DATA_W-1:0] dq_to_dev;
  logic [SDCP_DATA_W-1:0] dq_from_dev;
  logic dq_oe_n;
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    output addr, dqm, dq_to_dev,
    input dq_from_dev, dq_oe_n
  );
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    input addr, dqm, dq_to_dev,
    output dq_from_dev, dq_oe_n
  );
endinterface

// [sdcp_device.sv]
`timescale 1ns/1ps
module sdcp_device #(
  parameter int DEPTH_LOG2 = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  sdcp_if.dev link,
  // Array read and write side
  output logic mem_we,
  output logic [1:0] mem_bank,
  output logic [sdcp_pkg::SDCP_COL_W-1:0] mem_col,
  output logic [sdcp_pkg::SDCP_DATA_W-1:0] mem_wdata,
  input wire logic [sdcp_pkg::SDCP_DATA_W-1:0] mem_rdata,
  // Status
  output logic [sdcp_pkg::SDCP_BANKS-1:0] bank_open,
  output logic self_refresh,
  output logic power_down,
  output logic suspended,
  output logic [sdcp_pkg::SDCP_BANKS-1:0] autopre_start
);
  import sdcp_pkg::*;

  typedef enum logic [1:0] {SDCP_B_IDLE, SDCP_B_RD, SDCP_B_WR} sdcp_burst_t;

  sdcp_burst_t burst;
  logic cke_q;
  logic clk_en;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [2:0] burst_len_code;
  logic interleave;
  logic [2:0] cas_lat;
  logic [SDCP_COL_W-1:0] col_base;
  logic [SDCP_COL_W-1:0] beat;
  logic [SDCP_COL_W-1:0] last_beat;
  logic [1:0] burst_bank;
  logic burst_ap;
  logic [2:0] wr_rec;
  logic wr_rec_act;
  logic [1:0] wr_rec_bank;
  logic [SDCP_DATA_W-1:0] rd_pipe [8];
  logic [7:0] rd_vld;
  logic rd_now;
  logic burst_last;
  logic bank_any;

  function automatic logic [SDCP_COL_W-1:0] sdcp_len(input logic [2:0] code);
    unique case (code)
      SDCP_BL_2: sdcp_len = 9'h001;
      SDCP_BL_4: sdcp_len = 9'h003;
      SDCP_BL_8: sdcp_len = 9'h007;
      SDCP_BL_FULL: sdcp_len = 9'h1ff;
      default: sdcp_len = 9'h000;
    endcase
  endfunction

  // Column of the current beat
  function automatic logic [SDCP_COL_W-1:0] sdcp_col(
    input logic [SDCP_COL_W-1:0] base, input logic [SDCP_COL_W-1:0] b,
    input logic [SDCP_COL_W-1:0] mask, input logic il);
    if (il) begin
      sdcp_col = (base & ~mask) | ((base ^ b) & mask);
    end else begin
      sdcp_col = (base & ~mask) | ((base + b) & mask);
    end
  endfunction

  // clock enable sampled one edge earlier gates operation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cke_q <= 1'b1;
    end else begin
      cke_q <= link.cke;
    end
  end
  assign clk_en = cke_q && !self_refresh;
  assign cmd = link.cs_n ? SDCP_CMD_DESEL :
    {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign bank = {link.bank_select_high, link.bank_select_low};
  assign bank_any = |bank_open;
  assign burst_last = (beat == last_beat);

  // Power states
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      self_refresh <= 1'b0;
      power_down <= 1'b0;
      suspended <= 1'b0;
    end else if (self_refresh) begin
      if (link.cke) begin
        self_refresh <= 1'b0;
      end
    end else if (cke_q && !link.cke) begin
      if (cmd == SDCP_CMD_REF && !bank_any) begin
        self_refresh <= 1'b1;
      end else if (bank_any || burst != SDCP_B_IDLE) begin
        suspended <= 1'b1;
      end else begin
        power_down <= 1'b1;
      end
    end else if (!cke_q && link.cke) begin
      suspended <= 1'b0;
      power_down <= 1'b0;
    end
  end

  // Mode register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      burst_len_code <= SDCP_BL_RESET;
      interleave <= 1'b0;
      cas_lat <= SDCP_CL_RESET;
    end else if (clk_en && cmd == SDCP_CMD_MRS) begin
      burst_len_code <= link.addr[SDCP_MODE_BL_LSB +: 3];
      interleave <= link.addr[SDCP_MODE_BT_BIT];
      cas_lat <= link.addr[SDCP_MODE_CL_LSB +: 3];
    end
  end

  // Bank state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_open <= '0;
    end else begin
      if (clk_en && cmd == SDCP_CMD_ACT) begin
        bank_open[bank] <= 1'b1;
      end
      if (clk_en && cmd == SDCP_CMD_PRE) begin
        if (link.addr[SDCP_AP_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[bank] <= 1'b0;
        end
      end
      for (int i = 0; i < SDCP_BANKS; i++) begin
        if (autopre_start[i]) begin
          bank_open[i] <= 1'b0;
        end
      end
    end
  end

  // Auto-precharge start: reads CL beats early, writes tWR after last data
  always_comb begin
    autopre_start = '0;
    if (clk_en && burst == SDCP_B_RD && burst_ap &&
        {6'h00, cas_lat} + beat == last_beat + 9'h001) begin
      autopre_start[burst_bank] = 1'b1;
    end
    if (wr_rec_act && wr_rec == 3'(SDCP_TWR_CYC)) begin
      autopre_start[wr_rec_bank] = 1'b1;
    end
  end

  // Burst engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      burst <= SDCP_B_IDLE;
      col_base <= '0;
      beat <= '0;
      last_beat <= '0;
      burst_bank <= '0;
      burst_ap <= 1'b0;
    end else if (clk_en) begin
      if (cmd == SDCP_CMD_READ || cmd == SDCP_CMD_WRITE) begin
        burst <= (cmd == SDCP_CMD_READ) ? SDCP_B_RD : SDCP_B_WR;
        col_base <= link.addr[SDCP_COL_W-1:0];
        beat <= '0;
        last_beat <= sdcp_len(burst_len_code);
        burst_bank <= bank;
        burst_ap <= link.addr[SDCP_AP_BIT] &&
          burst_len_code != SDCP_BL_FULL;
      end else if (cmd == SDCP_CMD_STOP ||
          (burst != SDCP_B_IDLE && burst_last)) begin
        burst <= SDCP_B_IDLE;
      end else if (burst != SDCP_B_IDLE) begin
        beat <= beat + 9'h001;
      end
    end
  end

  // Write recovery counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_rec_act <= 1'b0;
      wr_rec <= '0;
      wr_rec_bank <= '0;
    end else if (clk_en && burst == SDCP_B_WR && burst_ap && burst_last &&
        cmd != SDCP_CMD_READ && cmd != SDCP_CMD_WRITE) begin
      wr_rec_act <= 1'b1;
      wr_rec <= 3'h1;
      wr_rec_bank <= burst_bank;
    end else if (wr_rec_act) begin
      if (wr_rec == 3'(SDCP_TWR_CYC)) begin
        wr_rec_act <= 1'b0;
      end else begin
        wr_rec <= wr_rec + 3'h1;
      end
    end
  end

  // Array access: write data taken with command and each following beat
  assign rd_now = clk_en && burst == SDCP_B_RD;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_we <= 1'b0;
      mem_bank <= '0;
      mem_col <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we <= 1'b0;
      if (clk_en && cmd == SDCP_CMD_WRITE) begin
        mem_we <= !link.dqm;
        mem_bank <= bank;
        mem_col <= link.addr[SDCP_COL_W-1:0];
        mem_wdata <= link.dq_to_dev;
      end else if (clk_en && burst == SDCP_B_WR && !burst_last) begin
        mem_we <= !link.dqm;
        mem_bank <= burst_bank;
        mem_col <= sdcp_col(col_base, beat + 9'h001,
          sdcp_len(burst_len_code), interleave);
        mem_wdata <= link.dq_to_dev;
      end else if (clk_en && cmd == SDCP_CMD_READ) begin
        mem_bank <= bank;
        mem_col <= link.addr[SDCP_COL_W-1:0];
      end else if (rd_now && !burst_last) begin
        mem_bank <= burst_bank;
        mem_col <= sdcp_col(col_base, beat + 9'h001,
          sdcp_len(burst_len_code), interleave);
      end
    end
  end

  // Read latency pipe, CAS latency deep, frozen during suspend
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_vld <= '0;
      for (int i = 0; i < 8; i++) begin
        rd_pipe[i] <= '0;
      end
    end else if (clk_en) begin
      rd_vld <= {rd_vld[6:0], rd_now};
      rd_pipe[0] <= mem_rdata;
      for (int i = 1; i < 8; i++) begin
        rd_pipe[i] <= rd_pipe[i-1];
      end
    end
  end

  assign link.dq_from_dev = rd_pipe[cas_lat - 3'h1];
  assign link.dq_oe_n = !(rd_vld[cas_lat - 3'h1] && cas_lat != 3'h0);
endmodule

// [sdcp_ctrl.sv]
`timescale 1ns/1ps
module sdcp_ctrl #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire sdcp_pkg::sdcp_op_t req_op,
  input wire logic [1:0] req_bank,
  input wire logic [sdcp_pkg::SDCP_ROW_W-1:0] req_addr,
  input wire logic [sdcp_pkg::SDCP_DATA_W-1:0] req_wdata,
  // Read data out
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sdcp_pkg::SDCP_DATA_W-1:0] rd_data,
  // Link
  sdcp_if.ctrl link
);
  import sdcp_pkg::*;

  logic [SDCP_DATA_W-1:0] buf_q [DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [1:0] count;
  logic dq_oe_n_s1;
  logic dq_oe_n_s2;
  logic [SDCP_DATA_W-1:0] dq_s1;
  logic [SDCP_DATA_W-1:0] dq_s2;
  logic [3:0] wait_cnt;
  logic in_sref;
  logic push;
  logic pop;
  // Landing store: a whole burst of up to eight words arrives unstoppably
  logic [SDCP_DATA_W-1:0] land_q [8];
  logic [3:0] land_wr;
  logic [3:0] land_rd;
  logic land_any;

  // a self refresh request holds clock enable low until a NOP request
  assign req_ready = (wait_cnt == 4'h0) && (count < 2'(DEPTH)) && !land_any;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.cke <= 1'b1;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_NOP;
      link.bank_select_low <= 1'b0;
      link.bank_select_high <= 1'b0;
      link.addr <= '0;
      link.dqm <= 1'b1;
      link.dq_to_dev <= '0;
      in_sref <= 1'b0;
      wait_cnt <= '0;
    end else begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_NOP;
      link.dqm <= 1'b0;
      if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (in_sref) begin
        if (req_valid && req_op == SDCP_OP_NOP) begin
          link.cke <= 1'b1;
          in_sref <= 1'b0;
          wait_cnt <= 4'(SDCP_TRP_CYC);
        end
      end else if (req_valid && req_ready) begin
        link.bank_select_low <= req_bank[0];
        link.bank_select_high <= req_bank[1];
        link.addr <= req_addr;
        link.dq_to_dev <= req_wdata;
        unique case (req_op)
          SDCP_OP_NOP: ;
          SDCP_OP_ACT: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_ACT;
          end
          SDCP_OP_READ: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_READ;
            // Hold off until the burst has landed
            wait_cnt <= 4'hf;
          end
          SDCP_OP_WRITE: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_WRITE;
            if (req_addr[SDCP_AP_BIT]) begin
              wait_cnt <= 4'hf;
            end
          end
          SDCP_OP_PRE: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_PRE;
            wait_cnt <= 4'(SDCP_TRP_CYC);
          end
          SDCP_OP_REF: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_REF;
            wait_cnt <= 4'(SDCP_TRP_CYC);
          end
          SDCP_OP_SREF: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_REF;
            link.cke <= 1'b0;
            in_sref <= 1'b1;
          end
          SDCP_OP_MRS: begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= SDCP_CMD_MRS;
            wait_cnt <= 4'(SDCP_TMRD_CYC);
          end
        endcase
      end
    end
  end

  // Read data pins pass two flip-flops before use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dq_oe_n_s1 <= 1'b1;
      dq_oe_n_s2 <= 1'b1;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_oe_n_s1 <= link.dq_oe_n;
      dq_oe_n_s2 <= dq_oe_n_s1;
      dq_s1 <= link.dq_from_dev;
      dq_s2 <= dq_s1;
    end
  end

  // Read words land first, then move into the two-entry output buffer
  assign land_any = land_wr != land_rd;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      land_wr <= '0;
    end else if (!dq_oe_n_s2) begin
      land_q[land_wr[2:0]] <= dq_s2;
      land_wr <= land_wr + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      land_rd <= '0;
    end else if (push) begin
      land_rd <= land_rd + 4'h1;
    end
  end
  assign push = land_any && count < 2'(DEPTH);
  assign pop = rd_valid && rd_ready;
  assign rd_valid = count != 2'h0;
  assign rd_data = buf_q[rd_ptr[0]];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        buf_q[i] <= '0;
      end
    end else begin
      if (push) begin
        buf_q[wr_ptr[0]] <= land_q[land_rd[2:0]];
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule

// [sdcp_monitor.sv]
`timescale 1ns/1ps
module sdcp_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [sdcp_pkg::SDCP_ROW_W-1:0] addr,
  input wire logic dq_oe_n,
  // Device status
  input wire logic [sdcp_pkg::SDCP_BANKS-1:0] bank_open,
  input wire logic self_refresh,
  input wire logic suspended,
  input wire logic [sdcp_pkg::SDCP_BANKS-1:0] autopre_start
);
  import sdcp_pkg::*;
  logic cke_q;
  logic [3:0] cmd;
  logic [1:0] bk;
  logic live;
  logic sref_in;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign bk = {bank_select_high, bank_select_low};
  // Commands count only while the device clock is running
  assign live = cke_q && cke && !self_refresh && !suspended;
  assign sref_in = cke_q && !cke && cmd == SDCP_CMD_REF;
  always_ff @(posedge clk_sys) begin
    cke_q <= rst | cke;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_act_opens_bank: assert property (
    live && cmd == SDCP_CMD_ACT |=> bank_open[$past(bk)])
    else $error("activate left bank closed");
  chk_pre_all_banks: assert property (
    live && cmd == SDCP_CMD_PRE && addr[SDCP_AP_BIT] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  chk_pre_one_bank: assert property (
    live && cmd == SDCP_CMD_PRE && !addr[SDCP_AP_BIT]
    |=> !bank_open[$past(bk)])
    else $error("bank precharge left bank open");
  chk_pre_act_gap: assert property (
    cmd == SDCP_CMD_PRE |=> cmd != SDCP_CMD_ACT)
    else $error("activate too soon after precharge");
  chk_wake_nop: assert property (
    $rose(cke) |-> (cs_n || cmd == SDCP_CMD_NOP) [*2])
    else $error("command too soon after clock enable rise");
  chk_sref_idle: assert property (
    sref_in |-> bank_open == 4'h0)
    else $error("self refresh with a bank open");
  chk_sref_hold: assert property (
    sref_in |=> !cke && self_refresh)
    else $error("self refresh not held");
  chk_read_drives: assert property (
    live && cmd == SDCP_CMD_READ && bank_open[bk] |-> ##[1:3] !dq_oe_n)
    else $error("read data not driven");
  chk_ap_pulse: assert property (
    live && (cmd == SDCP_CMD_READ || cmd == SDCP_CMD_WRITE)
    && addr[SDCP_AP_BIT] && bank_open[bk] |-> ##[1:12] autopre_start != 4'h0)
    else $error("auto precharge never started");
  cov_read: cover property (live && cmd == SDCP_CMD_READ);
  cov_sref: cover property (sref_in);
  cov_wake: cover property ($rose(cke));
endmodule

// [sdcp_tb.sv]
`timescale 1ns/1ps
module sdcp_tb;
  import sdcp_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic req_valid = 1'h0;
  logic req_ready;
  sdcp_op_t req_op = SDCP_OP_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic rd_valid;
  logic rd_ready = 1'h1;
  logic [15:0] rd_data;
  logic mem_we;
  logic [1:0] mem_bank;
  logic [8:0] mem_col;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [3:0] bank_open;
  logic [3:0] autopre_start;
  logic self_refresh;
  logic power_down;
  logic suspended;
  logic [15:0] mem [0:2047];
  logic [15:0] exp_w [0:7];
  integer seed = 1;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  sdcp_if link ();
  always #5 clk_sys = ~clk_sys;
  assign mem_rdata = mem[{mem_bank, mem_col}];
  sdcp_ctrl i_sdcp_ctrl (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .link(link));
  sdcp_device i_sdcp_device (.clk_sys(clk_sys), .rst(rst), .link(link),
    .mem_we(mem_we), .mem_bank(mem_bank), .mem_col(mem_col),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .bank_open(bank_open),
    .self_refresh(self_refresh), .power_down(power_down),
    .suspended(suspended), .autopre_start(autopre_start));
  sdcp_monitor i_sdcp_monitor (.clk_sys(clk_sys), .rst(rst),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n),
    .bank_select_low(link.bank_select_low),
    .bank_select_high(link.bank_select_high), .addr(link.addr),
    .dq_oe_n(link.dq_oe_n), .bank_open(bank_open),
    .self_refresh(self_refresh), .suspended(suspended),
    .autopre_start(autopre_start));
  // Array model, random read stalls and the hang limit
  always @(posedge clk_sys) begin
    if (mem_we) begin
      mem[{mem_bank, mem_col}] <= mem_wdata;
    end
    rd_ready <= |($random(seed) & 3);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  function automatic logic [11:0] mode_word(input logic [2:0] bl);
    return {5'h00, SDCP_CL_RESET, 1'h1, bl};
  endfunction
  function automatic logic [2:0] beat_col(input logic [2:0] s,
                                          input logic [2:0] k);
    return s ^ k;
  endfunction
  task automatic req(input sdcp_op_t op, input logic [1:0] bk,
                     input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req_op <= op;
    req_bank <= bk;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'h1 && n < 100);
    req_valid <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic read_burst(input logic [1:0] bk, input logic [8:0] col,
                            input int n, input logic ap);
    int w;
    int t;
    w = 0;
    t = 0;
    req(SDCP_OP_READ, bk, {1'h0, ap, 1'h0, col}, 16'h0000);
    while (w < n && t < 200) begin
      @(posedge clk_sys);
      t++;
      if (rd_valid === 1'h1 && rd_ready === 1'h1) begin
        check(rd_data, exp_w[beat_col(col[2:0], 3'(w))], "burst word");
        w++;
      end
    end
    check(16'(w), 16'(n), "burst word count");
  endtask
  initial begin
    logic [1:0] b;
    logic [5:0] h;
    logic [2:0] s;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    b = 2'($random(seed));
    h = 6'($random(seed));
    // Single beats fill an aligned group of eight columns
    req(SDCP_OP_PRE, 2'h0, 12'h400, 16'h0000);
    req(SDCP_OP_MRS, 2'h0, mode_word(SDCP_BL_1), 16'h0000);
    req(SDCP_OP_ACT, b, 12'($random(seed)), 16'h0000);
    for (int k = 0; k < 8; k++) begin
      exp_w[k] = 16'($random(seed));
      req(SDCP_OP_WRITE, b, {1'h0, 1'(k == 7), 1'h0, h, 3'(k)}, exp_w[k]);
    end
    repeat (6) @(posedge clk_sys);
    check(16'(bank_open), 16'h0000, "write autoprecharge");
    $display("test single writes done");
    for (int i = 1; i < 4; i++) begin
      s = 3'($random(seed));
      req(SDCP_OP_PRE, 2'h0, 12'h400, 16'h0000);
      req(SDCP_OP_MRS, 2'h0, mode_word(3'(i)), 16'h0000);
      req(SDCP_OP_ACT, b, 12'($random(seed)), 16'h0000);
      read_burst(b, {h, s}, 1 << i, 1'(i == 3));
    end
    repeat (8) @(posedge clk_sys);
    check(16'(bank_open), 16'h0000, "read autoprecharge");
    $display("test interleave bursts done");
    req(SDCP_OP_ACT, b, 12'h000, 16'h0000);
    req(SDCP_OP_ACT, b ^ 2'h1, 12'h000, 16'h0000);
    repeat (2) @(posedge clk_sys);
    check(16'(bank_open), 16'((4'h1 << b) | (4'h1 << (b ^ 2'h1))),
          "activate");
    req(SDCP_OP_PRE, b, 12'h000, 16'h0000);
    repeat (2) @(posedge clk_sys);
    check(16'(bank_open), 16'(4'h1 << (b ^ 2'h1)), "bank precharge");
    req(SDCP_OP_PRE, 2'h0, 12'h400, 16'h0000);
    repeat (2) @(posedge clk_sys);
    check(16'(bank_open), 16'h0000, "precharge all");
    $display("test precharge done");
    req(SDCP_OP_SREF, 2'h0, 12'h000, 16'h0000);
    repeat (4) @(posedge clk_sys);
    check(16'({self_refresh, link.cke}), 16'h0002, "self refresh");
    req(SDCP_OP_NOP, 2'h0, 12'h000, 16'h0000);
    repeat (4) @(posedge clk_sys);
    check(16'({self_refresh, link.cke}), 16'h0001, "refresh exit");
    req(SDCP_OP_ACT, b, 12'h000, 16'h0000);
    read_burst(b, {h, s}, 8, 1'h0);
    check(16'({power_down, suspended}), 16'h0000, "stray suspend");
    $display("test self refresh done");
    results;
  end
endmodule
